// ---- hdl/nvmcp_pkg.sv ----
// Constants and types for the nonvolatile access and protection block
package nvmcp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_FLAGS2 = 10'h00D;
    localparam logic [9:0] IDX_IRQEN2 = 10'h08D;
    localparam logic [9:0] IDX_DATA_LO = 10'h10C;
    localparam logic [9:0] IDX_ADDR_LO = 10'h10D;
    localparam logic [9:0] IDX_DATA_HI = 10'h10E;
    localparam logic [9:0] IDX_ADDR_HI = 10'h10F;
    localparam logic [9:0] IDX_CTRL = 10'h18C;
    localparam logic [9:0] IDX_KEY = 10'h18D;
    // Control register fields
    localparam int CTRL_SPACE = 7;
    localparam int CTRL_ERASE = 4;
    localparam int CTRL_FAULT = 3;
    localparam int CTRL_MODEN = 2;
    localparam int CTRL_WR = 1;
    localparam int CTRL_RD = 0;
    // Done flag and enable position
    localparam int DONE_BIT = 4;
    localparam logic DONE_RST = 1'b0;
    localparam logic DONE_EN_RST = 1'b0;
    // Unlock key values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // Self-program lock field codes and limits
    localparam logic [1:0] LOCK_NONE = 2'h3;
    localparam logic [1:0] LOCK_SMALL = 2'h2;
    localparam logic [1:0] LOCK_HALF = 2'h1;
    localparam logic [11:0] LIM_SMALL = 12'h100;
    localparam logic [11:0] LIM_HALF = 12'h800;
    // Power-up timer
    localparam int CLK_MHZ = 100;
    localparam int PUT_TIME_US = 72000;
    localparam int PUT_CYCLES = PUT_TIME_US * CLK_MHZ;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CPU = 2'b01,
        ST_EXT = 2'b10
    } nvmcp_state_e;
endpackage

// ---- hdl/nvmcp_top.sv ----
// Nonvolatile memory access, unlock and code protection logic
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - CPU data EEPROM access unaffected by protection
// - Data protect refuses all programmer data access
// - Data protect refuses programmer program writes
// - Code protect leaves CPU program access working
// - Lock field blocks self-writes in region
// - Code protect refuses programmer program access
// - Unlock key stores nothing, reads zero
// - Data high holds six bits, rest zero
// - Address/data registers kept through resets
// - Reset clears modify, write, read bits
// - Modify enable cleared at power-up
// - No CPU modification while power-up timer runs
module nvmcp_top #(
    parameter int PUT_N = nvmcp_pkg::PUT_CYCLES
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic PWR_ON,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Configuration word
    input wire logic CFG_DATA_PROT,
    input wire logic CFG_CODE_PROT,
    input wire logic [1:0] CFG_LOCK,
    // Programming port
    input wire logic PGM_REQ,
    input wire logic PGM_WRITE,
    input wire logic PGM_SPACE,
    input wire logic [11:0] PGM_ADDR,
    input wire logic [13:0] PGM_WDATA,
    output logic PGM_ACK,
    output logic PGM_REFUSED,
    output logic [13:0] PGM_RDATA,
    // Memory array port
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic MEM_ERASE,
    output logic MEM_SPACE,
    output logic [11:0] MEM_ADDR,
    output logic [13:0] MEM_WDATA,
    input wire logic MEM_DONE,
    input wire logic [13:0] MEM_RDATA
);
    import nvmcp_pkg::*;

    ////////////////////////////////////////////////////////////
    // Input synchronisers, no reset so PWR_ON survives reset
    logic [33:0] s1_r;
    logic [33:0] s2_r;
    wire [33:0] raw = {PWR_ON, CFG_DATA_PROT, CFG_CODE_PROT, CFG_LOCK,
        PGM_REQ, PGM_WRITE, PGM_SPACE, PGM_ADDR, PGM_WDATA};
    always_ff @(posedge MCLK) begin
        s1_r <= raw;
        s2_r <= s1_r;
    end
    wire pwr_on = s2_r[33];
    wire dprot = s2_r[32];
    wire cprot = s2_r[31];
    wire [1:0] lock = s2_r[30:29];
    wire x_req = s2_r[28];
    wire x_wr = s2_r[27];
    wire x_space = s2_r[26];
    wire [11:0] x_addr = s2_r[25:14];
    wire [13:0] x_wdata = s2_r[13:0];

    ////////////////////////////////////////////////////////////
    // State
    nvmcp_state_e state_r;
    logic [7:0] data_lo_r;
    logic [7:0] addr_lo_r;
    logic [5:0] data_hi_r;
    logic [3:0] addr_hi_r;
    logic space_r, erase_r, fault_r, moden_r, wr_r, rd_r;
    logic done_r, done_en_r;
    logic [1:0] key_r;
    logic [31:0] put_cnt_r;
    logic xreq_d_r;
    logic xpend_r, xwr_r, xspace_r;
    logic [11:0] xaddr_r;
    logic [13:0] xwdata_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic ack_r, refused_r;
    logic [13:0] rdata_r;
    logic mreq_r, mwe_r, merase_r, mspace_r;
    logic [11:0] maddr_r;
    logic [13:0] mwdata_r;

    ////////////////////////////////////////////////////////////
    // APB decode
    wire [9:0] idx = PADDR[11:2];
    wire apb_setup = PSEL & ~PENABLE;
    wire apb_acc = PSEL & PENABLE & pready_r;
    wire wr_acc = apb_acc & PWRITE;
    wire hit = (idx == IDX_FLAGS2) | (idx == IDX_IRQEN2) |
        (idx == IDX_DATA_LO) | (idx == IDX_ADDR_LO) |
        (idx == IDX_DATA_HI) | (idx == IDX_ADDR_HI) |
        (idx == IDX_CTRL) | (idx == IDX_KEY);
    wire w_flags = wr_acc & (idx == IDX_FLAGS2);
    wire w_irqen = wr_acc & (idx == IDX_IRQEN2);
    wire w_dlo = wr_acc & (idx == IDX_DATA_LO);
    wire w_alo = wr_acc & (idx == IDX_ADDR_LO);
    wire w_dhi = wr_acc & (idx == IDX_DATA_HI);
    wire w_ahi = wr_acc & (idx == IDX_ADDR_HI);
    wire w_ctrl = wr_acc & (idx == IDX_CTRL);
    wire w_key = wr_acc & (idx == IDX_KEY);
    wire [7:0] ctrl_rd = {space_r, 2'b00, erase_r, fault_r,
        moden_r, wr_r, rd_r};
    wire [7:0] flags_rd = 8'(done_r) << DONE_BIT;
    wire [7:0] irqen_rd = 8'(done_en_r) << DONE_BIT;
    // Key location reads zero data high zero-extended
    wire [7:0] rmux =
        (idx == IDX_FLAGS2) ? flags_rd :
        (idx == IDX_IRQEN2) ? irqen_rd :
        (idx == IDX_DATA_LO) ? data_lo_r :
        (idx == IDX_ADDR_LO) ? addr_lo_r :
        (idx == IDX_DATA_HI) ? {2'b00, data_hi_r} :
        (idx == IDX_ADDR_HI) ? {4'h0, addr_hi_r} :
        (idx == IDX_CTRL) ? ctrl_rd : 8'h00;

    ////////////////////////////////////////////////////////////
    // Start conditions
    wire put_busy = (put_cnt_r != 32'h0);
    wire [11:0] cpu_addr = {addr_hi_r, addr_lo_r};
    wire in_lock = (lock == LOCK_SMALL) ? (cpu_addr < LIM_SMALL) :
        (lock == LOCK_HALF) ? (cpu_addr < LIM_HALF) :
        (lock != LOCK_NONE);
    wire cpu_idle = ~rd_r & ~wr_r & (state_r != ST_CPU);
    wire wr_try = w_ctrl & PWDATA[CTRL_WR] & PWDATA[CTRL_MODEN] &
        (key_r == 2'h2) & cpu_idle;
    // Power-up timer and lock region stop the write
    wire wr_block = put_busy | (PWDATA[CTRL_SPACE] & in_lock);
    // CPU access ignores both protect bits
    wire rd_go = w_ctrl & PWDATA[CTRL_RD] & cpu_idle;
    wire done_set = (state_r == ST_CPU) & MEM_DONE & wr_r;
    wire done_rd = (state_r == ST_CPU) & MEM_DONE & rd_r;
    wire x_new = x_req & ~xreq_d_r;
    // Refusal on protection
    wire x_refuse = (dprot & (~x_space | x_wr)) | (cprot & x_space);

    ////////////////////////////////////////////////////////////
    // APB answer, one wait-free access cycle
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= apb_setup;
            pslverr_r <= apb_setup & ~hit;
            if (apb_setup) begin
                prdata_r <= {24'h0, rmux};
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Address and data registers, never reset
    always_ff @(posedge MCLK) begin
        if (!SYS_RST) begin
            if (w_alo) begin
                addr_lo_r <= PWDATA[7:0];
            end
            if (w_ahi) begin
                addr_hi_r <= PWDATA[3:0];
            end
            if (w_dlo) begin
                data_lo_r <= PWDATA[7:0];
            end else if (done_rd) begin
                data_lo_r <= MEM_RDATA[7:0];
            end
            if (w_dhi) begin
                data_hi_r <= PWDATA[5:0];
            end else if (done_rd & space_r) begin
                data_hi_r <= MEM_RDATA[13:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Power-up timer, loaded by a power-on reset
    always_ff @(posedge MCLK) begin
        if (SYS_RST && pwr_on) begin
            put_cnt_r <= 32'(PUT_N);
        end else if (put_busy) begin
            put_cnt_r <= put_cnt_r - 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////
    // Control, unlock and flags
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            moden_r <= 1'b0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            key_r <= 2'h0;
            space_r <= 1'b0;
            erase_r <= 1'b0;
            done_r <= DONE_RST;
            done_en_r <= DONE_EN_RST;
            if (!pwr_on) begin
                fault_r <= wr_r | fault_r;
            end
        end else begin
            if (w_ctrl) begin
                space_r <= PWDATA[CTRL_SPACE];
                erase_r <= PWDATA[CTRL_ERASE];
                moden_r <= PWDATA[CTRL_MODEN];
            end
            // Hardware set wins over a software clear
            if (wr_try & wr_block) begin
                fault_r <= 1'b1;
            end else if (w_ctrl) begin
                fault_r <= PWDATA[CTRL_FAULT];
            end
            if (wr_try & ~wr_block) begin
                wr_r <= 1'b1;
            end else if (done_set) begin
                wr_r <= 1'b0;
            end
            if (rd_go) begin
                rd_r <= 1'b1;
            end else if (done_rd) begin
                rd_r <= 1'b0;
            end
            // Key writes only step the detector
            if (w_key) begin
                if (PWDATA[7:0] == KEY_FIRST) begin
                    key_r <= 2'h1;
                end else if (PWDATA[7:0] == KEY_SECOND && key_r == 2'h1) begin
                    key_r <= 2'h2;
                end else begin
                    key_r <= 2'h0;
                end
            end else if (wr_acc) begin
                key_r <= 2'h0;
            end
            done_r <= done_set | (w_flags ? PWDATA[DONE_BIT] : done_r);
            if (w_irqen) begin
                done_en_r <= PWDATA[DONE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Access engine and programming port
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_r <= ST_IDLE;
            xreq_d_r <= 1'b0;
            xpend_r <= 1'b0;
            ack_r <= 1'b0;
            refused_r <= 1'b0;
            rdata_r <= 14'h0;
            mreq_r <= 1'b0;
            mwe_r <= 1'b0;
            merase_r <= 1'b0;
            mspace_r <= 1'b0;
        end else begin
            xreq_d_r <= x_req;
            ack_r <= 1'b0;
            refused_r <= 1'b0;
            if (x_new & x_refuse) begin
                ack_r <= 1'b1;
                refused_r <= 1'b1;
                rdata_r <= 14'h0;
            end else if (x_new) begin
                xpend_r <= 1'b1;
                xwr_r <= x_wr;
                xspace_r <= x_space;
                xaddr_r <= x_addr;
                xwdata_r <= x_wdata;
            end
            case (state_r)
                ST_IDLE: begin
                    if (rd_r | wr_r) begin
                        state_r <= ST_CPU;
                        mreq_r <= 1'b1;
                        mwe_r <= wr_r;
                        merase_r <= wr_r & erase_r;
                        mspace_r <= space_r;
                        maddr_r <= cpu_addr;
                        mwdata_r <= {data_hi_r, data_lo_r};
                    end else if (xpend_r) begin
                        state_r <= ST_EXT;
                        mreq_r <= 1'b1;
                        mwe_r <= xwr_r;
                        merase_r <= 1'b0;
                        mspace_r <= xspace_r;
                        maddr_r <= xaddr_r;
                        mwdata_r <= xwdata_r;
                    end
                end
                ST_CPU: begin
                    if (MEM_DONE) begin
                        state_r <= ST_IDLE;
                        mreq_r <= 1'b0;
                        mwe_r <= 1'b0;
                    end
                end
                ST_EXT: begin
                    if (MEM_DONE) begin
                        state_r <= ST_IDLE;
                        mreq_r <= 1'b0;
                        mwe_r <= 1'b0;
                        xpend_r <= 1'b0;
                        ack_r <= 1'b1;
                        rdata_r <= MEM_RDATA;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // Outputs
    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign PGM_ACK = ack_r;
    assign PGM_REFUSED = refused_r;
    assign PGM_RDATA = rdata_r;
    assign MEM_REQ = mreq_r;
    assign MEM_WE = mwe_r;
    assign MEM_ERASE = merase_r;
    assign MEM_SPACE = mspace_r;
    assign MEM_ADDR = maddr_r;
    assign MEM_WDATA = mwdata_r;

    ////////////////////////////////////////////////////////////
    // Checks
    chk_cpu_read_free: assert property (@(posedge MCLK) disable iff (SYS_RST)
        rd_go |=> rd_r) else $error("cpu read refused");
    chk_data_refused: assert property (@(posedge MCLK) disable iff (SYS_RST)
        x_new & dprot & ~x_space |=> refused_r & ack_r)
        else $error("data access not refused");
    chk_pwrite_refused: assert property (@(posedge MCLK) disable iff (SYS_RST)
        x_new & dprot & x_wr |=> refused_r ##1 !mreq_r)
        else $error("program write not refused");
    chk_lock_blocks: assert property (@(posedge MCLK) disable iff (SYS_RST)
        wr_try & PWDATA[CTRL_SPACE] & in_lock |=> !wr_r && fault_r)
        else $error("locked region written");
    chk_code_refused: assert property (@(posedge MCLK) disable iff (SYS_RST)
        x_new & cprot & x_space |=> refused_r && !xpend_r)
        else $error("program access not refused");
    chk_key_zero: assert property (@(posedge MCLK) disable iff (SYS_RST)
        apb_setup & (idx == IDX_KEY) |=> PRDATA == 32'h0)
        else $error("key location not zero");
    chk_high_six: assert property (@(posedge MCLK) disable iff (SYS_RST)
        apb_setup & (idx == IDX_DATA_HI) |=> PRDATA[31:6] == 26'h0)
        else $error("data high upper bits set");
    chk_regs_kept: assert property (@(posedge MCLK) disable iff (SYS_RST)
        $past(SYS_RST) && !pwr_on |-> addr_lo_r == $past(addr_lo_r, 2))
        else $error("address changed by reset");
    chk_reset_clear: assert property (@(posedge MCLK) disable iff (SYS_RST)
        $past(SYS_RST) |-> !moden_r && !wr_r && !rd_r)
        else $error("control bits not cleared");
    chk_put_blocks: assert property (@(posedge MCLK) disable iff (SYS_RST)
        wr_try & put_busy |=> !wr_r ##1 !mwe_r)
        else $error("write during power-up timer");
    chk_refuse_zero: assert property (@(posedge MCLK) disable iff (SYS_RST)
        refused_r |-> PGM_RDATA == 14'h0 && state_r != ST_EXT)
        else $error("refused access leaked data");
endmodule

`default_nettype wire

// ---- tb/nvmcp_mem_model.sv ----
// Behavioural memory array standing behind the access block
`timescale 1ns/1ps
`default_nettype none
module nvmcp_mem_model (
    // Clock and latency
    input wire logic mclk,
    input wire logic [3:0] lat,
    // Array request side
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_erase,
    input wire logic mem_space,
    input wire logic [11:0] mem_addr,
    input wire logic [13:0] mem_wdata,
    output logic mem_done,
    output logic [13:0] mem_rdata
);
    logic [13:0] mem [0:8191];
    int cnt;
    logic served;
    initial begin
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 14'h3FFF;
        end
        mem_done = 1'b0;
        mem_rdata = 14'h1234;
        served = 1'b0;
        cnt = 0;
    end
    // Read data is only meaningful with the done pulse
    always @(posedge mclk) begin
        mem_done <= 1'b0;
        mem_rdata <= {mem_rdata[12:0], ~mem_rdata[13]};
        if (mem_req !== 1'b1) begin
            served <= 1'b0;
            cnt <= 0;
        end else if (!served) begin
            if (cnt < lat) begin
                cnt <= cnt + 1;
            end else begin
                mem_done <= 1'b1;
                served <= 1'b1;
                mem_rdata <= mem[{mem_space, mem_addr}];
                if (mem_we) begin
                    mem[{mem_space, mem_addr}] = mem_erase ? 14'h3FFF : mem_wdata;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the nonvolatile access block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import nvmcp_pkg::*;
    logic MCLK, SYS_RST, PWR_ON, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [11:0] PADDR, PGM_ADDR, MEM_ADDR;
    logic [31:0] PWDATA, PRDATA, rd, lo;
    logic CFG_DATA_PROT, CFG_CODE_PROT, PGM_REQ, PGM_WRITE, PGM_SPACE, PGM_ACK, PGM_REFUSED;
    logic [1:0] CFG_LOCK;
    logic [13:0] PGM_WDATA, PGM_RDATA, MEM_WDATA, MEM_RDATA, rdat;
    logic MEM_REQ, MEM_WE, MEM_ERASE, MEM_SPACE, MEM_DONE, err, ref_q, req_q;
    logic [3:0] lat;
    int num_errors, compares, nreq, nd;
    int exp_mem [int];

    nvmcp_top #(.PUT_N(20)) i_dut (
        .MCLK(MCLK), .SYS_RST(SYS_RST), .PWR_ON(PWR_ON), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .CFG_DATA_PROT(CFG_DATA_PROT), .CFG_CODE_PROT(CFG_CODE_PROT),
        .CFG_LOCK(CFG_LOCK), .PGM_REQ(PGM_REQ), .PGM_WRITE(PGM_WRITE), .PGM_SPACE(PGM_SPACE),
        .PGM_ADDR(PGM_ADDR), .PGM_WDATA(PGM_WDATA), .PGM_ACK(PGM_ACK),
        .PGM_REFUSED(PGM_REFUSED), .PGM_RDATA(PGM_RDATA), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
        .MEM_ERASE(MEM_ERASE), .MEM_SPACE(MEM_SPACE), .MEM_ADDR(MEM_ADDR),
        .MEM_WDATA(MEM_WDATA), .MEM_DONE(MEM_DONE), .MEM_RDATA(MEM_RDATA));
    nvmcp_mem_model i_mem (.mclk(MCLK), .lat(lat), .mem_req(MEM_REQ), .mem_we(MEM_WE),
        .mem_erase(MEM_ERASE), .mem_space(MEM_SPACE), .mem_addr(MEM_ADDR),
        .mem_wdata(MEM_WDATA), .mem_done(MEM_DONE), .mem_rdata(MEM_RDATA));

    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    // Counts array requests so refusals can be seen to issue none
    always @(posedge MCLK) begin
        req_q <= MEM_REQ;
        if (MEM_REQ === 1'b1 && req_q !== 1'b1) nreq++;
    end
    initial begin
        repeat (30000) @(posedge MCLK);
        num_errors++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_pgm(input logic eref, input logic [13:0] edat);
        check("programmer refused", {31'h0, eref}, {31'h0, ref_q});
        check("programmer data", {18'h0, edat}, {18'h0, rdat});
    endtask
    function automatic logic [13:0] expect_word(input logic sp, input logic [11:0] a);
        int k;
        k = sp * 4096 + a;
        return exp_mem.exists(k) ? exp_mem[k][13:0] : 14'h3FFF;
    endfunction
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= {idx, 2'b00};
        PWDATA <= wd;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do @(posedge MCLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // Starts a CPU read or unlocked write and waits for the engine
    task automatic cpu_op(input logic sp, input logic wr, input logic [11:0] a,
                          input logic [13:0] d);
        apb(1'b1, IDX_ADDR_LO, {24'h0, a[7:0]});
        apb(1'b1, IDX_ADDR_HI, {28'h0, a[11:8]});
        if (wr) begin
            apb(1'b1, IDX_DATA_LO, {24'h0, d[7:0]});
            apb(1'b1, IDX_DATA_HI, {26'h0, d[13:8]});
            apb(1'b1, IDX_KEY, {24'h0, KEY_FIRST});
            apb(1'b1, IDX_KEY, {24'h0, KEY_SECOND});
        end
        apb(1'b1, IDX_CTRL, {24'h0, sp, 4'h0, wr, wr, !wr});
        do apb(1'b0, IDX_CTRL, 32'h0); while (rd[1:0] !== 2'b00);
    endtask
    task automatic pgm(input logic sp, input logic wr, input logic [11:0] a,
                       input logic [13:0] d);
        int n0;
        n0 = nreq;
        @(posedge MCLK);
        PGM_SPACE <= sp;
        PGM_WRITE <= wr;
        PGM_ADDR <= a;
        PGM_WDATA <= d;
        PGM_REQ <= 1'b1;
        do @(posedge MCLK); while (PGM_ACK !== 1'b1);
        ref_q = PGM_REFUSED;
        rdat = PGM_RDATA;
        PGM_REQ <= 1'b0;
        repeat (4) @(posedge MCLK);
        nd = nreq - n0;
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [11:0] a, a1;
        logic [13:0] d;
        logic sp, wr, refd, blk;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, PGM_REQ, PGM_WRITE, PGM_SPACE} = '0;
        {PGM_ADDR, PGM_WDATA, CFG_DATA_PROT, CFG_CODE_PROT, lat} = '0;
        SYS_RST = 1'b1;
        PWR_ON = 1'b1;
        CFG_LOCK = LOCK_NONE;
        void'($urandom(32'h1367));
        repeat (5) @(posedge MCLK);
        SYS_RST <= 1'b0;
        PWR_ON <= 1'b0;
        apb(1'b0, IDX_CTRL, 32'h0);
        check("ctrl after power-on", 32'h0, {29'h0, rd[2:0]});
        apb(1'b1, IDX_KEY, {24'h0, KEY_FIRST});
        apb(1'b1, IDX_KEY, {24'h0, KEY_SECOND});
        apb(1'b1, IDX_CTRL, 32'h06);
        apb(1'b0, IDX_CTRL, 32'h0);
        check("write during power-up", 32'h2, {30'h0, rd[3], rd[1]});
        check("requests during power-up", 32'h0, nreq);
        apb(1'b0, IDX_KEY, 32'h0);
        check("key read", 32'h0, rd);
        apb(1'b1, IDX_DATA_HI, 32'hFF);
        apb(1'b0, IDX_DATA_HI, 32'h0);
        check("data high bits", 32'h3F, rd);
        apb(1'b0, 10'h000, 32'h0);
        check("unmapped", 32'h80000000, {err, rd[30:0]});
        apb(1'b1, IDX_CTRL, 32'h0);
        repeat (25) @(posedge MCLK);
        CFG_DATA_PROT <= 1'b1;
        CFG_CODE_PROT <= 1'b1;
        a1 = 12'($urandom_range(0, 255));
        d = 14'($urandom_range(0, 255));
        cpu_op(1'b0, 1'b1, a1, d);
        exp_mem[a1] = d;
        cpu_op(1'b0, 1'b0, a1, 14'h0);
        apb(1'b0, IDX_DATA_LO, 32'h0);
        check("protected data read", {24'h0, d[7:0]}, rd);
        for (int c = 0; c < 4; c++) begin
            CFG_LOCK <= 2'(c);
            for (int i = 0; i < 3; i++) begin
                a = (i == 0) ? 12'h050 : (i == 1) ? 12'h400 : 12'h900;
                blk = c == 0 || (c == 1 && a < LIM_HALF) || (c == 2 && a < LIM_SMALL);
                d = 14'($urandom);
                lat <= 4'($urandom_range(0, 6));
                cpu_op(1'b1, 1'b1, a, d);
                check("self write fault", {31'h0, blk}, {31'h0, rd[3]});
                if (!blk) exp_mem[4096 + a] = d;
                apb(1'b1, IDX_CTRL, 32'h0);
                cpu_op(1'b1, 1'b0, a, 14'h0);
                apb(1'b0, IDX_DATA_LO, 32'h0);
                lo = rd;
                apb(1'b0, IDX_DATA_HI, 32'h0);
                check("program word", {18'h0, expect_word(1'b1, a)}, {18'h0, rd[5:0], lo[7:0]});
            end
        end
        // Erase of an unlocked word; address still set by the last read
        apb(1'b1, IDX_KEY, {24'h0, KEY_FIRST});
        apb(1'b1, IDX_KEY, {24'h0, KEY_SECOND});
        apb(1'b1, IDX_CTRL, 32'h96);
        do apb(1'b0, IDX_CTRL, 32'h0); while (rd[1:0] !== 2'b00);
        exp_mem[4096 + 12'h900] = 14'h3FFF;
        cpu_op(1'b1, 1'b0, 12'h900, 14'h0);
        apb(1'b0, IDX_DATA_LO, 32'h0);
        lo = rd;
        apb(1'b0, IDX_DATA_HI, 32'h0);
        check("erased word", {18'h0, expect_word(1'b1, 12'h900)}, {18'h0, rd[5:0], lo[7:0]});
        for (int k = 0; k < 16; k++) begin
            CFG_DATA_PROT <= k[3];
            CFG_CODE_PROT <= k[2];
            sp = k[1];
            wr = k[0];
            repeat (3) @(posedge MCLK);
            a = sp ? 12'h400 : a1;
            d = sp ? 14'($urandom) : 14'($urandom_range(0, 255));
            refd = (k[3] && (!sp || wr)) || (k[2] && sp);
            lat <= 4'($urandom_range(0, 6));
            pgm(sp, wr, a, d);
            check("array requests", {31'h0, !refd}, nd);
            if (refd || !wr) check_pgm(refd, refd ? 14'h0 : expect_word(sp, a));
            if (!refd && wr) exp_mem[sp * 4096 + a] = d;
        end
        apb(1'b1, IDX_ADDR_LO, 32'h5A);
        apb(1'b1, IDX_ADDR_HI, 32'h3);
        apb(1'b1, IDX_CTRL, 32'h04);
        @(posedge MCLK);
        SYS_RST <= 1'b1;
        repeat (4) @(posedge MCLK);
        SYS_RST <= 1'b0;
        apb(1'b0, IDX_ADDR_LO, 32'h0);
        check("address low kept", 32'h5A, rd);
        apb(1'b0, IDX_ADDR_HI, 32'h0);
        check("address high kept", 32'h3, rd);
        apb(1'b0, IDX_CTRL, 32'h0);
        check("ctrl after reset", 32'h0, {29'h0, rd[2:0]});
        tally_and_finish();
    end
endmodule
`default_nettype wire
